// ===== design/psc_pkg.sv
package psc_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned SHORT_S     = 4;
	localparam int unsigned LONG_S      = 6;
	localparam int unsigned DEB_MS      = 16;
	localparam int unsigned MS_CYC      = CLK_HZ / 1000;
	localparam logic [12:0] SHORT_MS    = 13'(SHORT_S * 1000);
	localparam logic [12:0] LONG_MS     = 13'(LONG_S * 1000);
	localparam logic [12:0] PRESS_MAX   = 13'h1fff;
	localparam logic [4:0]  DEB_CNT     = 5'(DEB_MS);
	localparam int unsigned SYNC_W      = 7;

	// power states
	typedef enum logic [2:0] {
		ST_G3   = 3'h0,
		ST_S5   = 3'h1,
		ST_S4   = 3'h2,
		ST_S3   = 3'h3,
		ST_UP   = 3'h4,
		ST_WORK = 3'h5
	} psc_state_t;

	// target chosen by os power settings for a short press while working
	typedef enum logic [1:0] {
		SL_NONE = 2'h0,
		SL_S3   = 2'h1,
		SL_S4   = 2'h2,
		SL_S5   = 2'h3
	} psc_sleep_t;

	// behaviour after mains loss
	typedef enum logic [1:0] {
		LM_OFF  = 2'h0,
		LM_ON   = 2'h1,
		LM_LAST = 2'h2
	} psc_last_t;

	typedef struct packed {
		logic sw;
		logic rtc;
		logic lan;
		logic usb;
		logic pcie;
		logic ir;
	} psc_wake_t;

	typedef struct packed {
		logic main_en;
		logic dram_en;
	} psc_rail_t;

	typedef struct packed {
		logic pri;
		logic sec;
	} psc_led_t;
endpackage

// ===== design/psc_top.sv
`timescale 1ns/1ps
// What this block does
// - short press under four seconds: off to on, sleep to on, on to os-chosen sleep.
// - press held over six seconds while on or asleep forces soft-off.
// - after mains loss, return to the on or off state held before.
// - post-outage behaviour chosen by a stored last-state setting.
// - in suspend-to-ram the lamp shows secondary colour, or dark if single colour.
// - any enabled wake in suspend-to-ram returns promptly to working.
// - rtc alarm wakes from s3, s4, s5 with display left asleep.
// - programmed wake time wakes the system from soft-off.
// - network wake honoured from s3, s4, s5, even after mains loss.
// - usb activity wakes from s3, never after mains loss.
// - usb wake from s4/s5 needs option, never after mains loss or deep.
// - pci express wake line wakes from s3, s4, s5.
// - infrared receiver activity wakes from s3, s4, s5.
// - infrared wake ignored in deep s4 or deep s5.
// - no wake path from the short-range radio.
module psc_top
	import psc_pkg::*;
#(
	parameter int unsigned MS_CYCLES = MS_CYC
) (
	// clock and mains-loss reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// pins from outside the clock domain
	input  wire logic       pwr_sw_b,
	input  wire logic       rtc_alarm,
	input  wire logic       lan_wake,
	input  wire logic       usb_wake,
	input  wire logic       pcie_wake_b,
	input  wire logic       infrared_receiver,
	input  wire logic       pwr_ok,
	// configuration and os directives, same clock
	input  wire psc_last_t  last_mode,
	input  wire logic       nv_last_on,
	input  wire psc_sleep_t btn_tgt,
	input  wire logic       os_sleep_req,
	input  wire psc_sleep_t os_sleep_tgt,
	input  wire logic       usb_s45_en,
	input  wire logic       deep_sleep,
	input  wire logic       led_dual,
	// status and rails
	output psc_state_t      state,
	output psc_rail_t       rail,
	output psc_led_t        led,
	output logic            last_on,
	output logic            disp_stay_off,
	output psc_wake_t       wake_src,
	output logic            wake_pend
);

	if (MS_CYCLES < 2) begin : g_bad_ms
		$error("psc_top: MS_CYCLES must be at least 2");
	end

	// reset release through two flops
	logic rst_meta_ff;
	logic rst_sync_b;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_ff <= 1'b0;
			rst_sync_b  <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_b  <= rst_meta_ff;
		end
	end

	// two-flop synchronisers; first stage feeds only the second
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;
	assign pin_raw = {~pwr_sw_b, rtc_alarm, lan_wake, usb_wake, ~pcie_wake_b, infrared_receiver, pwr_ok};
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= pin_raw;
			sync2_ff <= sync1_ff;
		end
	end

	logic      sw_s;
	logic      pwr_ok_s;
	psc_wake_t req;
	assign sw_s     = sync2_ff[6];
	assign pwr_ok_s = sync2_ff[0];
	// lan line is raised by the network side on a wake-up frame
	assign req = '{sw: 1'b0, rtc: sync2_ff[5], lan: sync2_ff[4], usb: sync2_ff[3],
	               pcie: sync2_ff[2], ir: sync2_ff[1]};

	// millisecond enable from a divider
	logic [31:0] div_ff;
	logic        ms_tick;
	assign ms_tick = (div_ff == MS_CYCLES - 1);
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			div_ff <= '0;
		end else if (ms_tick) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 32'h1;
		end
	end

	// switch debounce: level must hold DEB_CNT ms before it is believed
	logic       sw_deb_ff;
	logic [4:0] deb_cnt_ff;
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sw_deb_ff  <= 1'b0;
			deb_cnt_ff <= '0;
		end else if (sw_s == sw_deb_ff) begin
			deb_cnt_ff <= '0;
		end else if (ms_tick) begin
			if (deb_cnt_ff == DEB_CNT - 5'h1) begin
				sw_deb_ff  <= sw_s;
				deb_cnt_ff <= '0;
			end else begin
				deb_cnt_ff <= deb_cnt_ff + 5'h1;
			end
		end
	end

	// press timer in ms, saturating; long press latches so release is inert
	logic        sw_prev_ff;
	logic [12:0] press_ff;
	logic        long_done_ff;
	logic        short_rel;
	logic        long_hit;
	logic        on_or_asleep;
	assign on_or_asleep = (state != ST_G3) && (state != ST_S5);
	assign short_rel = sw_prev_ff && !sw_deb_ff && !long_done_ff && (press_ff < SHORT_MS);
	// first held cycle still carries the count of an older press, so wait one cycle
	assign long_hit  = sw_deb_ff && sw_prev_ff && !long_done_ff && (press_ff > LONG_MS) && on_or_asleep;
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sw_prev_ff   <= 1'b0;
			press_ff     <= '0;
			long_done_ff <= 1'b0;
		end else begin
			sw_prev_ff <= sw_deb_ff;
			if (sw_deb_ff && !sw_prev_ff) begin
				press_ff     <= '0;
				long_done_ff <= 1'b0;
			end else if (sw_deb_ff && ms_tick && press_ff != PRESS_MAX) begin
				press_ff <= press_ff + 13'h1;
			end
			if (long_hit) begin
				long_done_ff <= 1'b1;
			end
		end
	end

	// state held after a mains loss until the system next reaches working
	logic after_g3_ff;
	logic asleep;
	logic s45;
	assign asleep = (state == ST_S3) || (state == ST_S4) || (state == ST_S5);
	assign s45    = (state == ST_S4) || (state == ST_S5);

	// wake gating per source; the radio has no input at all
	psc_wake_t en;
	psc_wake_t hit;
	logic      wake_now;
	always_comb begin
		en.sw   = asleep;
		en.rtc  = asleep;
		en.lan  = asleep;
		en.usb  = !after_g3_ff && ((state == ST_S3) ||
		          (s45 && usb_s45_en && !deep_sleep));
		en.pcie = asleep;
		en.ir   = asleep && !(s45 && deep_sleep);
		hit     = req & en;
		hit.sw  = short_rel && asleep;
		wake_now = |hit;
	end

	// power state machine
	psc_state_t nxt_state;
	always_comb begin
		nxt_state = state;
		case (state)
			ST_G3: begin
				if (last_mode == LM_ON || (last_mode == LM_LAST && nv_last_on)) begin
					nxt_state = ST_UP;
				end else begin
					nxt_state = ST_S5;
				end
			end
			ST_S5, ST_S4, ST_S3: begin
				if (long_hit) begin
					nxt_state = ST_S5;
				end else if (wake_now || wake_pend) begin
					nxt_state = ST_UP;
				end
			end
			ST_UP: begin
				if (long_hit) begin
					nxt_state = ST_S5;
				end else if (pwr_ok_s) begin
					nxt_state = ST_WORK;
				end
			end
			ST_WORK: begin
				if (long_hit) begin
					nxt_state = ST_S5;
				end else if (short_rel && btn_tgt != SL_NONE) begin
					nxt_state = psc_state_t'(3'h4 - {1'b0, btn_tgt});
				end else if (os_sleep_req && os_sleep_tgt != SL_NONE) begin
					nxt_state = psc_state_t'(3'h4 - {1'b0, os_sleep_tgt});
				end
			end
			default: nxt_state = ST_S5;
		endcase
	end

	// state, rails and lamp all registered from the next state
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state <= ST_G3;
			rail  <= '0;
			led   <= '0;
		end else begin
			state        <= nxt_state;
			rail.main_en <= (nxt_state == ST_UP) || (nxt_state == ST_WORK);
			rail.dram_en <= (nxt_state == ST_UP) || (nxt_state == ST_WORK) || (nxt_state == ST_S3);
			led.pri      <= (nxt_state == ST_WORK);
			led.sec      <= (nxt_state == ST_S3) && led_dual;
		end
	end

	// remembered on/off state; s3, s4 and power-up keep the last value, s5 clears it
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			last_on <= 1'b0;
		end else if (state == ST_WORK) begin
			last_on <= 1'b1;
		end else if (state == ST_S5) begin
			last_on <= 1'b0;
		end
	end

	// mains-loss marker: usb may not wake until working is reached again
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			after_g3_ff <= 1'b1;
		end else if (state == ST_WORK) begin
			after_g3_ff <= 1'b0;
		end
	end

	// merged wake event held until working or a long press; source flags kept for reading
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			wake_pend <= 1'b0;
			wake_src  <= '0;
		end else begin
			if (wake_now) begin
				wake_pend <= 1'b1;
			end else if (state == ST_WORK || long_hit) begin
				wake_pend <= 1'b0;
			end
			// a new hit in the clearing cycle wins over the clear
			if (wake_now) begin
				wake_src <= wake_src | hit;
			end else if (asleep && !wake_pend) begin
				wake_src <= '0;
			end
		end
	end

	// display kept asleep for unattended wakes until the user presses
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			disp_stay_off <= 1'b0;
		end else if (wake_now && !hit.sw) begin
			disp_stay_off <= 1'b1;
		end else if (sw_deb_ff || hit.sw) begin
			disp_stay_off <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	AST_LONG_OFF: assert property (long_hit |=> state == ST_S5)
		else $error("long press did not force soft-off");
	AST_SHORT_ON: assert property (short_rel && state == ST_S5 |=> state == ST_UP ##1 rail.main_en)
		else $error("short press from off did not power up");
	AST_SHORT_SLEEP: assert property (
		short_rel && !long_hit && state == ST_WORK && btn_tgt == SL_S3 |=> state == ST_S3 && !rail.main_en)
		else $error("short press did not enter os-chosen sleep");
	AST_LED_S3: assert property (state == ST_S3 |-> !led.pri && led.sec == $past(led_dual))
		else $error("lamp wrong in suspend-to-ram");
	AST_S3_WAKE: assert property (state == ST_S3 && wake_now && !long_hit |=> state == ST_UP)
		else $error("s3 wake not taken at once");
	AST_RTC_DISP: assert property (req.rtc && asleep && !hit.sw |=> disp_stay_off && wake_pend)
		else $error("rtc wake missing or display woke");
	AST_USB_G3: assert property (after_g3_ff |-> !hit.usb)
		else $error("usb woke after mains loss");
	AST_USB_S45: assert property (s45 && (!usb_s45_en || deep_sleep) |-> !hit.usb)
		else $error("usb woke from s4/s5 without option");
	AST_IR_DEEP: assert property (s45 && deep_sleep |-> !hit.ir)
		else $error("infrared woke from deep state");
	AST_LAN_ANY: assert property (req.lan && asleep |-> wake_now)
		else $error("lan wake dropped");
	AST_PEND_HOLD: assert property (wake_pend && state != ST_WORK && !long_hit |=> wake_pend)
		else $error("wake event lost before working");
	AST_LAST_ON: assert property (
		state == ST_G3 && last_mode == LM_LAST && nv_last_on |=> state == ST_UP ##1 rail.main_en)
		else $error("last on state not restored");

	COV_LONG: cover property (state == ST_WORK ##1 long_hit ##1 state == ST_S5);
	COV_S3_WAKE: cover property (state == ST_S3 ##1 state == ST_UP ##[1:100] state == ST_WORK);
	COV_RTC_S5: cover property (state == ST_S5 && hit.rtc);
	COV_RESTORE: cover property (state == ST_G3 ##1 state == ST_UP);

endmodule

// ===== sim/psc_wake_model.sv
`timescale 1ns/1ps
module psc_wake_model (
	// clock and rail feedback
	input  wire logic clk,
	input  wire logic main_en,
	// pins toward the controller
	output logic      pwr_sw_b,
	output logic      rtc_alarm,
	output logic      lan_wake,
	output logic      usb_wake,
	output logic      pcie_wake_b,
	output logic      infrared_receiver,
	output logic      pwr_ok
);
	int pok_dly = 3;
	int pok_cnt = 0;
	// switch open and wake lines quiet at power-up
	initial begin
		pwr_sw_b = 1'h1;
		pcie_wake_b = 1'h1;
		{rtc_alarm, lan_wake, usb_wake, infrared_receiver, pwr_ok} = 5'h0;
	end
	// supply reports good a while after the main rail, so a slow supply stretches power-up
	always @(posedge clk) begin
		pok_cnt <= main_en ? pok_cnt + 1 : 0;
		pwr_ok  <= #1 main_en && pok_cnt >= pok_dly;
	end
	// switch held for the given cycles, then opened
	task automatic press(input int cyc);
		@(posedge clk);
		#1 pwr_sw_b = 1'h0;
		repeat (cyc) @(posedge clk);
		#1 pwr_sw_b = 1'h1;
	endtask
	// one wake line: 0 rtc, 1 lan, 2 usb, 3 pcie, 4 infrared
	task automatic drive(input int src, input logic lvl);
		case (src)
			0: rtc_alarm = lvl;
			1: lan_wake = lvl;
			2: usb_wake = lvl;
			3: pcie_wake_b = !lvl;
			default: infrared_receiver = lvl;
		endcase
	endtask
	// level held long enough to pass the synchronisers
	task automatic wake(input int src);
		@(posedge clk);
		#1 drive(src, 1'h1);
		repeat (10) @(posedge clk);
		#1 drive(src, 1'h0);
	endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
	import psc_pkg::*;
	localparam int MS = 4;
	logic       clk = 1'h0;
	logic       rst_b = 1'h0;
	psc_last_t  last_mode = LM_OFF;
	logic       nv_last_on = 1'h0;
	psc_sleep_t btn_tgt = SL_S3;
	logic       os_sleep_req = 1'h0;
	psc_sleep_t os_sleep_tgt = SL_NONE;
	logic       usb_s45_en = 1'h0;
	logic       deep_sleep = 1'h0;
	logic       led_dual = 1'h1;
	logic       pwr_sw_b, rtc_alarm, lan_wake, usb_wake, pcie_wake_b, infrared_receiver, pwr_ok;
	psc_state_t state;
	psc_rail_t  rail;
	psc_led_t   led;
	psc_wake_t  wake_src;
	logic       last_on, disp_stay_off, wake_pend;
	int         bad_count = 0;
	int         n_tests = 0;
	logic [7:0] tab [8];

	psc_top #(.MS_CYCLES(MS)) uut (.clk(clk), .rst_b(rst_b), .pwr_sw_b(pwr_sw_b), .rtc_alarm(rtc_alarm),
		.lan_wake(lan_wake), .usb_wake(usb_wake), .pcie_wake_b(pcie_wake_b),
		.infrared_receiver(infrared_receiver), .pwr_ok(pwr_ok), .last_mode(last_mode),
		.nv_last_on(nv_last_on), .btn_tgt(btn_tgt), .os_sleep_req(os_sleep_req),
		.os_sleep_tgt(os_sleep_tgt), .usb_s45_en(usb_s45_en), .deep_sleep(deep_sleep),
		.led_dual(led_dual), .state(state), .rail(rail), .led(led), .last_on(last_on),
		.disp_stay_off(disp_stay_off), .wake_src(wake_src), .wake_pend(wake_pend));
	psc_wake_model wm (.clk(clk), .main_en(rail.main_en), .pwr_sw_b(pwr_sw_b), .rtc_alarm(rtc_alarm),
		.lan_wake(lan_wake), .usb_wake(usb_wake), .pcie_wake_b(pcie_wake_b),
		.infrared_receiver(infrared_receiver), .pwr_ok(pwr_ok));

	// 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
		end
	endtask
	// bounded wait; running out ends the run as a failure
	task automatic wait_st(input psc_state_t s, input int lim);
		int i;
		i = 0;
		while (state !== s && i < lim) begin
			@(posedge clk);
			#2;
			i++;
		end
		chk(state, s, "state");
		if (state !== s) print_verdict();
	endtask
	// mains loss held three cycles
	task automatic do_reset(input psc_last_t m, input logic nv);
		@(posedge clk);
		#1 rst_b = 1'h0;
		last_mode = m;
		nv_last_on = nv;
		deep_sleep = 1'h0; // usb after mains loss must be refused by the marker alone
		repeat (3) @(posedge clk);
		#1 chk({state, rail, led}, 8'h0, "reset outputs");
		rst_b = 1'h1;
	endtask
	task automatic go_sleep(input psc_sleep_t t);
		@(posedge clk);
		#1 os_sleep_req = 1'h1;
		os_sleep_tgt = t;
		@(posedge clk);
		#1 os_sleep_req = 1'h0;
	endtask

	initial begin
		tab = '{{SL_S4, 3'h0, 2'h0, 1'h1}, {SL_S3, 3'h1, 2'h0, 1'h1}, {SL_S4, 3'h3, 2'h0, 1'h1},
			{SL_S5, 3'h4, 2'h0, 1'h1}, {SL_S4, 3'h4, 2'h2, 1'h0}, {SL_S5, 3'h2, 2'h0, 1'h0},
			{SL_S4, 3'h2, 2'h1, 1'h1}, {SL_S5, 3'h2, 2'h3, 1'h0}};
		do_reset(LM_OFF, 1'h0);
		wait_st(ST_S5, 10);
		wm.press(50 * MS);
		chk(state, ST_S5, "no action before release");
		wait_st(ST_UP, 2000);
		chk(wake_src, 8'h20, "switch source");
		wait_st(ST_WORK, 100);
		// last_on follows working by one edge
		@(posedge clk);
		#2 chk({rail, led, last_on}, 8'h1d, "working outputs");
		go_sleep(SL_S3);
		wait_st(ST_S3, 10);
		chk({rail, led}, 8'h5, "s3 rails and lamp");
		#1 led_dual = 1'h0;
		repeat (2) @(posedge clk);
		#2 chk(led, 8'h0, "single lamp dark");
		#1 led_dual = 1'h1;
		wm.pok_dly = 40; // slow supply keeps the power-up state long enough to see
		wm.wake(2);
		wait_st(ST_UP, 50);
		chk({wake_pend, disp_stay_off, wake_src}, 8'hc4, "usb wake");
		wait_st(ST_WORK, 100);
		repeat (2) @(posedge clk);
		#2 chk(wake_pend, 8'h0, "pending cleared");
		// every short-press target, then a short press back to work
		for (int t = 1; t < 4; t++) begin
			@(posedge clk);
			#1 btn_tgt = psc_sleep_t'(t);
			wm.press(50 * MS);
			wait_st(psc_state_t'(3'(4 - t)), 2000);
			chk(disp_stay_off, 8'h0, "switch wakes display");
			wm.press(50 * MS);
			wait_st(ST_WORK, 2000);
		end
		// short press with no action chosen leaves working alone
		@(posedge clk);
		#1 btn_tgt = SL_NONE;
		wm.press(50 * MS);
		repeat (100) @(posedge clk);
		#2 chk(state, ST_WORK, "short press ignored");
		// wake sources by sleep state, option and deep variant
		for (int k = 0; k < 8; k++) begin
			go_sleep(psc_sleep_t'(tab[k][7:6]));
			wait_st(psc_state_t'(3'h4 - {1'h0, tab[k][7:6]}), 10);
			repeat (3) @(posedge clk);
			#1 {deep_sleep, usb_s45_en} = tab[k][2:1];
			wm.wake(int'(tab[k][5:3]));
			if (tab[k][0]) begin
				wait_st(ST_UP, 50);
				chk({disp_stay_off, 1'h0, wake_src}, 8'h80 | (8'h10 >> tab[k][5:3]), "source");
				wait_st(ST_WORK, 200);
			end else begin
				repeat (30) @(posedge clk);
				#2 chk({wake_pend, state}, {5'h0, 3'h4 - {1'h0, tab[k][7:6]}}, "ignored");
				// os sleep requests only act from working, so come back first
				wm.press(50 * MS);
				wait_st(ST_WORK, 2000);
			end
		end
		wm.press(6200 * MS);
		chk({state, last_on}, {ST_S5, 1'h0}, "long press");
		repeat (400) @(posedge clk);
		#2 chk(state, ST_S5, "release after long");
		do_reset(LM_LAST, 1'h1);
		wait_st(ST_UP, 10);
		do_reset(LM_ON, 1'h0);
		wait_st(ST_UP, 10);
		do_reset(LM_LAST, 1'h0);
		wait_st(ST_S5, 10);
		wm.wake(2);
		repeat (30) @(posedge clk);
		#2 chk(state, ST_S5, "usb after mains loss");
		wm.wake(1);
		wait_st(ST_UP, 50);
		print_verdict();
	end
endmodule
